/* rtl/lpt_dev_end.sv */
// Contract
// RL1: information field limit settable 708..3345 octets
// RL2: transmit time limit bounds only concatenation
// RL3: busy notice command starts 120 s busy timer
// RL4: connectionless frames shorter than 9 are invalid
// RL5: expired queued test response is dropped
// RL6: acknowledgment timer 10..1800 s, default 120
// RL7: poll timer 10..60 s, default 10
// RL8: reject timer capped at twice acknowledgment timer
// RL9: timers start when frame actually sent
// RL10: connection resends limited 0..5, default 2
// RL11: unacknowledged I frames limited by window
// RL12: send ack request at outstanding threshold
// RL13: acknowledge at received in-sequence threshold
// RL14: delayed ack after percentage of ack timer
// RL15: U frames min 9, I/S min 10
// RL16: per-destination timeout plus physical delay
// RL17: busy notice response starts busy timer
// RL18: connectionless resends limited 0..5, quiet suppresses
// RL19: both stations use identical parameter values
// RL20: quiet mode blocks acks and resends
// RL21: short received frames discarded unprocessed
// RL22: retry count clears on ack; fail at limit
`include "lpt_consts.svh"
`default_nettype none
module lpt_dev_end #(
  parameter int MS_CYC = `LPT_MS_NS / `LPT_CLK_NS,
  parameter int BUSY_S = `LPT_BUSY_S
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  lpt_link_if.dev link,
  input wire lpt_pkg::lpt_cfg_t i_cfg,
  input wire logic i_cfg_load,
  input wire logic i_tx_valid,
  input wire lpt_pkg::lpt_frame_t i_tx_frame,
  output logic o_tx_ready,
  input wire logic [15:0] i_concat_ms,
  output logic o_concat_ok,
  input wire logic i_test_rsp_queued,
  input wire logic i_test_rsp_sent,
  output logic o_test_rsp_drop,
  output logic o_rx_valid,
  output lpt_pkg::lpt_frame_t o_rx_frame,
  output logic o_rx_discard,
  output logic o_peer_busy,
  output logic o_retx_req,
  output logic o_link_fail,
  output logic [`LPT_DEST_N-1:0] o_retx_dest,
  output logic [`LPT_DEST_N-1:0] o_fail_dest
);
  import lpt_pkg::*;
  localparam int DW = $clog2(MS_CYC + 1);
  localparam int TW = `LPT_TMR_W;
  localparam logic [TW-1:0] T_ONE = TW'(1);

  lpt_cfg_t cfg_r;
  logic [DW-1:0] div_r;
  logic tick;
  logic rx_ok, rx_i, tx_v, tx_i, tx_go, user_ok, auto_v, ack_any, conn_exp, dly_exp;
  lpt_frame_t rx_f, tx_f, auto_f;
  logic d2p_v_r;
  lpt_frame_t d2p_f_r;
  logic [7:0] out_sum, out_nxt;
  logic [6:0] out_r, rx_cnt_r, ack_amt;
  logic auto_req_r, auto_rr_r, dec_rr_r;
  logic [`LPT_DEST_W-1:0] dec_dest_r;
  logic [TW-1:0] ack_t_r, poll_t_r, rej_t_r, dly_t_r, busy_t_r, ttl_t_r;
  logic [11:0] rej_eff;
  logic [2:0] retry_r;

  // ----------------------------------------
  // Millisecond tick and settings
  // ----------------------------------------
  assign tick = (div_r == DW'(MS_CYC - 1));

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_r <= '0;
    end else begin
      div_r <= tick ? '0 : DW'(div_r + 1'b1);
    end
  end

  // Settings are meant to be loaded once, before traffic starts
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_r <= LPT_CFG_DFLT;
    end else if (i_cfg_load) begin
      cfg_r <= lpt_cfg_fix(i_cfg); // RL1 RL6 RL7 RL10 RL11 RL19
    end
  end

  assign o_concat_ok = (i_concat_ms <= cfg_r.max_tx_time_ms); // RL2
  assign rej_eff = (12'(cfg_r.rej_s) > 12'({cfg_r.ack_s, 1'b0})) ? 12'({cfg_r.ack_s, 1'b0}) : cfg_r.rej_s; // RL8

  // ----------------------------------------
  // Receive
  // ----------------------------------------
  assign rx_f = link.p2d_frame;
  assign rx_ok = link.p2d_valid & lpt_len_ok(rx_f, cfg_r.max_info_len); // RL21 RL4 RL15
  assign rx_i = rx_ok & (rx_f.kind inside {LPT_I_CMD, LPT_I_RSP});
  assign ack_any = rx_ok & (rx_f.ack_cnt != '0);

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_valid <= 1'b0;
      o_rx_discard <= 1'b0;
      o_rx_frame <= '0;
    end else begin
      o_rx_valid <= rx_ok;
      o_rx_discard <= link.p2d_valid & ~rx_ok; // RL21
      if (rx_ok) begin
        o_rx_frame <= rx_f;
      end
    end
  end

  // ----------------------------------------
  // Transmit arbitration, own frames first
  // ----------------------------------------
  always_comb begin
    auto_f = '0;
    auto_v = 1'b1;
    if (auto_req_r) begin
      auto_f.kind = LPT_S_ACKREQ; // RL12
      auto_f.pf = 1'b1;
      auto_f.ack_cnt = rx_cnt_r;
    end else if (auto_rr_r) begin
      auto_f.kind = LPT_S_RR; // RL13 RL14
      auto_f.ack_cnt = rx_cnt_r;
    end else if (dec_rr_r) begin
      auto_f.kind = LPT_DEC_RR; // RL20
      auto_f.dest = dec_dest_r;
    end else begin
      auto_v = 1'b0;
    end
    auto_f.len = lpt_is_long(auto_f.kind) ? 12'(`LPT_MIN_LEN_IS) : 12'(`LPT_MIN_LEN_U);
  end

  assign tx_v = d2p_v_r;
  assign tx_f = d2p_f_r;
  assign tx_i = tx_v & (tx_f.kind inside {LPT_I_CMD, LPT_I_RSP});
  assign user_ok = ((i_tx_frame.kind != LPT_I_CMD && i_tx_frame.kind != LPT_I_RSP)
                    || (8'(out_r) + 8'(tx_i) < 8'(cfg_r.window))) // RL11
                   && !(o_peer_busy && i_tx_frame.kind inside {LPT_UI, LPT_TEST_CMD});
  assign o_tx_ready = ~auto_v & user_ok;
  assign tx_go = i_tx_valid & o_tx_ready & lpt_len_ok(i_tx_frame, cfg_r.max_info_len); // RL1 RL4 RL15

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      d2p_v_r <= 1'b0;
      d2p_f_r <= '0;
    end else begin
      d2p_v_r <= auto_v | tx_go;
      if (auto_v | tx_go) begin
        d2p_f_r <= auto_v ? auto_f : i_tx_frame;
      end
    end
  end

  assign link.d2p_valid = d2p_v_r;
  assign link.d2p_frame = d2p_f_r;
  assign link.d2p_key = d2p_v_r;

  // ----------------------------------------
  // Window and acknowledgment counts
  // ----------------------------------------
  // The last frame stays on an idle link, so only a valid one may acknowledge
  assign ack_amt = rx_ok ? rx_f.ack_cnt : 7'h00;
  assign out_sum = 8'(out_r) + 8'(tx_i);
  assign out_nxt = (out_sum > 8'(ack_amt)) ? 8'(out_sum - 8'(ack_amt)) : 8'h00;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_r <= '0;
    end else begin
      out_r <= 7'(out_nxt); // RL11
    end
  end

  // Set wins over the clear taken in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      auto_req_r <= 1'b0;
    end else if (tx_i && out_sum == 8'(cfg_r.k2)) begin
      auto_req_r <= 1'b1; // RL12
    end else if (auto_req_r) begin
      auto_req_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_cnt_r <= '0;
    end else if (auto_v && !auto_req_r && !auto_rr_r) begin
      rx_cnt_r <= (rx_i && rx_cnt_r != 7'h7F) ? 7'(rx_cnt_r + 1'b1) : rx_cnt_r;
    end else if (auto_v) begin
      rx_cnt_r <= rx_i ? 7'h01 : 7'h00;
    end else if (rx_i && rx_cnt_r != 7'h7F) begin
      rx_cnt_r <= 7'(rx_cnt_r + 1'b1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      auto_rr_r <= 1'b0;
    end else if (!cfg_r.quiet && ((rx_i && 8'(rx_cnt_r) + 8'h01 >= 8'(cfg_r.k3)) // RL13 RL20
                 || (dly_exp && rx_cnt_r != '0 && !i_tx_valid))) begin // RL14
      auto_rr_r <= 1'b1;
    end else if (auto_v && !auto_req_r) begin
      auto_rr_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dec_rr_r <= 1'b0;
      dec_dest_r <= '0;
    end else if (rx_ok && rx_f.kind == LPT_DEC_INFO && !cfg_r.quiet) begin
      dec_rr_r <= 1'b1; // RL20
      dec_dest_r <= rx_f.dest;
    end else if (auto_v && !auto_req_r && !auto_rr_r) begin
      dec_rr_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Connection timers, started on the link
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_t_r <= '0;
    end else if ((tx_v && tx_f.kind inside {LPT_I_CMD, LPT_I_RSP, LPT_U_CMD} && ack_t_r == '0) // RL9
                 || (ack_any && out_nxt != '0)) begin
      ack_t_r <= TW'(cfg_r.ack_s) * TW'(`LPT_MS_PER_S); // RL6
    end else if (rx_ok && ((ack_any && out_nxt == '0) || rx_f.kind == LPT_U_RSP)) begin
      ack_t_r <= '0;
    end else if (tick && ack_t_r != '0) begin
      ack_t_r <= TW'(ack_t_r - 1'b1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      poll_t_r <= '0;
    end else if (tx_v && tx_f.pf && tx_f.kind inside {LPT_I_CMD, LPT_S_ACKREQ, LPT_U_CMD}) begin
      poll_t_r <= TW'(cfg_r.poll_s) * TW'(`LPT_MS_PER_S); // RL7 RL9
    end else if (rx_ok && rx_f.pf && rx_f.kind inside {LPT_I_RSP, LPT_S_RR, LPT_U_RSP}) begin
      poll_t_r <= '0;
    end else if (tick && poll_t_r != '0) begin
      poll_t_r <= TW'(poll_t_r - 1'b1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rej_t_r <= '0;
    end else if (tx_v && tx_f.kind inside {LPT_S_REJ, LPT_S_SREJ}) begin
      rej_t_r <= TW'(rej_eff) * TW'(`LPT_MS_PER_S); // RL8 RL9
    end else if (rx_i) begin
      rej_t_r <= '0;
    end else if (tick && rej_t_r != '0) begin
      rej_t_r <= TW'(rej_t_r - 1'b1);
    end
  end

  // Zero percent expires the delay at once instead of loading an idle timer
  assign dly_exp = (tick && dly_t_r == T_ONE)
                   || (rx_ok && rx_f.kind inside {LPT_I_RSP, LPT_I_CMD} && !(rx_f.kind == LPT_I_CMD && rx_f.pf)
                       && cfg_r.dly_pct == '0);

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dly_t_r <= '0;
    end else if (rx_ok && (rx_f.kind == LPT_I_RSP || (rx_f.kind == LPT_I_CMD && !rx_f.pf))) begin
      dly_t_r <= TW'(TW'(cfg_r.ack_s) * TW'(cfg_r.dly_pct) * TW'(`LPT_MS_PER_PCT_S)); // RL14
    end else if (tick && dly_t_r != '0) begin
      dly_t_r <= TW'(dly_t_r - 1'b1);
    end
  end

  assign conn_exp = tick && (ack_t_r == T_ONE || poll_t_r == T_ONE || rej_t_r == T_ONE);

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      retry_r <= '0;
      o_retx_req <= 1'b0;
      o_link_fail <= 1'b0;
    end else begin
      o_retx_req <= conn_exp && !cfg_r.quiet && retry_r < cfg_r.conn_retry; // RL10 RL20
      o_link_fail <= conn_exp && !cfg_r.quiet && retry_r >= cfg_r.conn_retry; // RL22
      if (ack_any || (rx_ok && rx_f.pf)) begin
        retry_r <= '0; // RL22
      end else if (conn_exp && !cfg_r.quiet && retry_r < cfg_r.conn_retry) begin
        retry_r <= 3'(retry_r + 1'b1);
      end
    end
  end

  // ----------------------------------------
  // Busy and test response lifetime
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_t_r <= '0;
      o_peer_busy <= 1'b0;
    end else if (rx_ok && rx_f.kind inside {LPT_BUSY_CMD, LPT_BUSY_RSP}) begin
      busy_t_r <= TW'(BUSY_S * `LPT_MS_PER_S); // RL3 RL17
      o_peer_busy <= 1'b1;
    end else if ((rx_ok && rx_f.kind == LPT_READY) || (tick && busy_t_r == T_ONE)) begin
      busy_t_r <= '0;
      o_peer_busy <= 1'b0;
    end else if (tick && busy_t_r != '0) begin
      busy_t_r <= TW'(busy_t_r - 1'b1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ttl_t_r <= '0;
      o_test_rsp_drop <= 1'b0;
    end else begin
      o_test_rsp_drop <= tick && ttl_t_r == T_ONE && !i_test_rsp_sent; // RL5
      if (i_test_rsp_queued) begin
        ttl_t_r <= TW'(cfg_r.ttl_ms); // RL5
      end else if (i_test_rsp_sent) begin
        ttl_t_r <= '0;
      end else if (tick && ttl_t_r != '0) begin
        ttl_t_r <= TW'(ttl_t_r - 1'b1);
      end
    end
  end

  // ----------------------------------------
  // Connectionless timeout per destination
  // ----------------------------------------
  for (genvar g = 0; g < `LPT_DEST_N; g++) begin : g_dest
    logic [TW-1:0] t_r;
    logic [2:0] n_r;
    logic start, stop, expd;
    assign start = tx_v && tx_f.kind inside {LPT_UI, LPT_TEST_CMD} && tx_f.dest == `LPT_DEST_W'(g);
    assign stop = rx_ok && rx_f.kind inside {LPT_TEST_RSP, LPT_U_RSP} && rx_f.dest == `LPT_DEST_W'(g);
    assign expd = tick && t_r == T_ONE && !stop;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        t_r <= '0;
      end else if (stop) begin
        t_r <= '0;
      end else if (start) begin
        t_r <= TW'(cfg_r.tp_ms[g]) + TW'(cfg_r.phy_delay_ms); // RL16 RL9
      end else if (tick && t_r != '0) begin
        t_r <= TW'(t_r - 1'b1);
      end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        n_r <= '0;
        o_retx_dest[g] <= 1'b0;
        o_fail_dest[g] <= 1'b0;
      end else begin
        o_retx_dest[g] <= expd && !cfg_r.quiet && n_r < cfg_r.connless_retry; // RL18 RL20
        o_fail_dest[g] <= expd && !cfg_r.quiet && n_r >= cfg_r.connless_retry; // RL22
        if (stop) begin
          n_r <= '0;
        end else if (expd && !cfg_r.quiet && n_r < cfg_r.connless_retry) begin
          n_r <= 3'(n_r + 1'b1);
        end
      end
    end
  end
endmodule // lpt_dev_end
`default_nettype wire

/* pkg/lpt_consts.svh */
`ifndef LPT_CONSTS_SVH
`define LPT_CONSTS_SVH
`define LPT_CLK_NS 4
`define LPT_MS_NS 1000000
`define LPT_MS_PER_S 1000
`define LPT_MS_PER_PCT_S 10
`define LPT_LEN_W 12
`define LPT_TMR_W 21
`define LPT_DEST_N 4
`define LPT_DEST_W 2
`define LPT_MIN_LEN_U 9
`define LPT_MIN_LEN_IS 10
`define LPT_INFO_MIN 708
`define LPT_INFO_MAX 3345
`define LPT_BUSY_S 120
`define LPT_ACK_S_MIN 10
`define LPT_ACK_S_MAX 1800
`define LPT_ACK_S_DFLT 120
`define LPT_POLL_S_MIN 10
`define LPT_POLL_S_MAX 60
`define LPT_POLL_S_DFLT 10
`define LPT_REJ_S_DFLT 240
`define LPT_RETRY_MAX 5
`define LPT_RETRY_DFLT 2
`define LPT_SEQ_MIN 1
`define LPT_SEQ_MAX 127
`define LPT_WIN_DFLT 7
`define LPT_K2_DFLT 4
`define LPT_K3_DFLT 4
`define LPT_PCT_MAX 99
`define LPT_DLY_PCT_DFLT 50
`define LPT_MTT_MS_DFLT 5000
`define LPT_TTL_MS_DFLT 0
`define LPT_TP_MS_DFLT 10000
`define LPT_PHY_MS_DFLT 0
`endif

/* pkg/lpt_pkg.sv */
`include "lpt_consts.svh"
`default_nettype none
package lpt_pkg;
  typedef enum logic [3:0] {
    LPT_UI = 4'h0, LPT_I_CMD = 4'h1, LPT_I_RSP = 4'h2, LPT_S_RR = 4'h3,
    LPT_S_ACKREQ = 4'h4, LPT_S_REJ = 4'h5, LPT_S_SREJ = 4'h6, LPT_U_CMD = 4'h7,
    LPT_U_RSP = 4'h8, LPT_BUSY_CMD = 4'h9, LPT_BUSY_RSP = 4'hA, LPT_READY = 4'hB,
    LPT_TEST_CMD = 4'hC, LPT_TEST_RSP = 4'hD, LPT_DEC_RR = 4'hE, LPT_DEC_INFO = 4'hF
  } lpt_kind_t;

  typedef struct packed {
    lpt_kind_t kind;
    logic [`LPT_LEN_W-1:0] len;
    logic pf;
    logic [`LPT_DEST_W-1:0] dest;
    logic [6:0] ack_cnt;
  } lpt_frame_t;

  typedef struct packed {
    logic [`LPT_LEN_W-1:0] max_info_len;
    logic [15:0] max_tx_time_ms;
    logic [15:0] ttl_ms;
    logic [10:0] ack_s;
    logic [5:0] poll_s;
    logic [11:0] rej_s;
    logic [2:0] conn_retry;
    logic [2:0] connless_retry;
    logic [6:0] window;
    logic [6:0] k2;
    logic [6:0] k3;
    logic [6:0] dly_pct;
    logic [`LPT_DEST_N-1:0][15:0] tp_ms;
    logic [15:0] phy_delay_ms;
    logic quiet;
  } lpt_cfg_t;

  localparam lpt_cfg_t LPT_CFG_DFLT = '{
    max_info_len: 12'(`LPT_INFO_MAX), max_tx_time_ms: 16'(`LPT_MTT_MS_DFLT),
    ttl_ms: 16'(`LPT_TTL_MS_DFLT), ack_s: 11'(`LPT_ACK_S_DFLT), poll_s: 6'(`LPT_POLL_S_DFLT),
    rej_s: 12'(`LPT_REJ_S_DFLT), conn_retry: 3'(`LPT_RETRY_DFLT), connless_retry: 3'(`LPT_RETRY_DFLT),
    window: 7'(`LPT_WIN_DFLT), k2: 7'(`LPT_K2_DFLT), k3: 7'(`LPT_K3_DFLT),
    dly_pct: 7'(`LPT_DLY_PCT_DFLT), tp_ms: {`LPT_DEST_N{16'(`LPT_TP_MS_DFLT)}},
    phy_delay_ms: 16'(`LPT_PHY_MS_DFLT), quiet: 1'b0};

  function automatic int lpt_clamp(int v, int lo, int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Out-of-range settings are pulled to the nearest legal value
  function automatic lpt_cfg_t lpt_cfg_fix(lpt_cfg_t c);
    lpt_cfg_t f;
    f = c;
    f.max_info_len = 12'(lpt_clamp(int'(c.max_info_len), `LPT_INFO_MIN, `LPT_INFO_MAX));
    f.ack_s = 11'(lpt_clamp(int'(c.ack_s), `LPT_ACK_S_MIN, `LPT_ACK_S_MAX));
    f.poll_s = 6'(lpt_clamp(int'(c.poll_s), `LPT_POLL_S_MIN, `LPT_POLL_S_MAX));
    f.conn_retry = 3'(lpt_clamp(int'(c.conn_retry), 0, `LPT_RETRY_MAX));
    f.connless_retry = 3'(lpt_clamp(int'(c.connless_retry), 0, `LPT_RETRY_MAX));
    f.window = 7'(lpt_clamp(int'(c.window), `LPT_SEQ_MIN, `LPT_SEQ_MAX));
    f.k2 = 7'(lpt_clamp(int'(c.k2), `LPT_SEQ_MIN, `LPT_SEQ_MAX));
    f.k3 = 7'(lpt_clamp(int'(c.k3), `LPT_SEQ_MIN, `LPT_SEQ_MAX));
    f.dly_pct = 7'(lpt_clamp(int'(c.dly_pct), 0, `LPT_PCT_MAX));
    return f;
  endfunction

  function automatic logic lpt_is_long(lpt_kind_t k);
    return k inside {LPT_I_CMD, LPT_I_RSP, LPT_S_RR, LPT_S_ACKREQ, LPT_S_REJ, LPT_S_SREJ};
  endfunction

  function automatic logic lpt_len_ok(lpt_frame_t f, logic [`LPT_LEN_W-1:0] max_info);
    logic [`LPT_LEN_W-1:0] min_len;
    logic carries;
    min_len = lpt_is_long(f.kind) ? 12'(`LPT_MIN_LEN_IS) : 12'(`LPT_MIN_LEN_U);
    carries = f.kind inside {LPT_UI, LPT_I_CMD, LPT_I_RSP, LPT_DEC_INFO};
    return (f.len >= min_len) && (!carries || (12'(f.len - min_len) <= max_info));
  endfunction
endpackage
`default_nettype wire

/* pkg/lpt_link_if.sv */
`default_nettype none
interface lpt_link_if;
  logic d2p_valid;
  lpt_pkg::lpt_frame_t d2p_frame;
  logic d2p_key;
  logic p2d_valid;
  lpt_pkg::lpt_frame_t p2d_frame;
  logic p2d_key;
  modport dev(output d2p_valid, output d2p_frame, output d2p_key,
              input p2d_valid, input p2d_frame, input p2d_key);
  modport peer(input d2p_valid, input d2p_frame, input d2p_key,
               output p2d_valid, output p2d_frame, output p2d_key);
endinterface
`default_nettype wire

/* rtl/lpt_peer_end.sv */
`include "lpt_consts.svh"
`default_nettype none
module lpt_peer_end (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  lpt_link_if.peer link,
  input wire lpt_pkg::lpt_cfg_t i_cfg,
  input wire logic i_cfg_load,
  input wire logic i_tx_valid,
  input wire lpt_pkg::lpt_frame_t i_tx_frame,
  output logic o_tx_reject,
  output logic o_rx_valid,
  output lpt_pkg::lpt_frame_t o_rx_frame,
  output logic o_rx_discard
);
  import lpt_pkg::*;

  logic [`LPT_LEN_W-1:0] max_info_r;
  logic tx_v_r;
  lpt_frame_t tx_f_r;
  logic tx_ok;
  logic rx_ok;
  lpt_cfg_t cfg_fix;

  // Same clamping as the device end, so both ends agree on the limit
  assign cfg_fix = lpt_cfg_fix(i_cfg);

  // ----------------------------------------
  // Settings, same values as the device end
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      max_info_r <= LPT_CFG_DFLT.max_info_len;
    end else if (i_cfg_load) begin
      max_info_r <= cfg_fix.max_info_len; // RL1 RL19
    end
  end

  // ----------------------------------------
  // Transmit
  // ----------------------------------------
  assign tx_ok = lpt_len_ok(i_tx_frame, max_info_r); // RL4 RL15

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_v_r <= 1'b0;
      tx_f_r <= '0;
      o_tx_reject <= 1'b0;
    end else begin
      tx_v_r <= i_tx_valid & tx_ok;
      o_tx_reject <= i_tx_valid & ~tx_ok;
      if (i_tx_valid & tx_ok) begin
        tx_f_r <= i_tx_frame;
      end
    end
  end

  assign link.p2d_valid = tx_v_r;
  assign link.p2d_frame = tx_f_r;
  assign link.p2d_key = tx_v_r;

  // ----------------------------------------
  // Receive
  // ----------------------------------------
  assign rx_ok = link.d2p_valid & lpt_len_ok(link.d2p_frame, max_info_r); // RL1 RL4 RL15

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_valid <= 1'b0;
      o_rx_discard <= 1'b0;
      o_rx_frame <= '0;
    end else begin
      o_rx_valid <= rx_ok;
      o_rx_discard <= link.d2p_valid & ~rx_ok;
      if (rx_ok) begin
        o_rx_frame <= link.d2p_frame;
      end
    end
  end
endmodule // lpt_peer_end
`default_nettype wire

/* dv/lpt_assertions.sv */
`default_nettype none
module lpt_assertions (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic d2p_valid,
  input wire lpt_pkg::lpt_frame_t d2p_frame,
  input wire logic d2p_key,
  input wire logic p2d_valid,
  input wire lpt_pkg::lpt_frame_t p2d_frame,
  input wire logic p2d_key
);
  timeunit 1ns;
  timeprecision 1ps;
  import lpt_pkg::*;
  // ------------------------------
  // Frame length and key checks
  // ------------------------------
  function automatic logic lng(lpt_kind_t k);
    return k inside {LPT_I_CMD, LPT_I_RSP, LPT_S_RR, LPT_S_ACKREQ, LPT_S_REJ, LPT_S_SREJ};
  endfunction
  function automatic logic cry(lpt_kind_t k);
    return k inside {LPT_UI, LPT_I_CMD, LPT_I_RSP, LPT_DEC_INFO};
  endfunction
  // Ceiling is the absolute one, so it holds for any loaded limit
  function automatic logic [11:0] top(lpt_kind_t k);
    return lng(k) ? 12'hD1B : 12'hD1A;
  endfunction
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  AST_D_KEY: assert property (d2p_key == d2p_valid)
    else $error("dev key differs from valid");
  AST_P_KEY: assert property (p2d_valid |-> p2d_key ##1 (p2d_key == p2d_valid))
    else $error("peer key differs from valid");
  AST_D_MIN: assert property (d2p_valid |-> d2p_frame.len >= 12'h009)
    else $error("dev frame too short");
  AST_P_MIN: assert property (p2d_valid |-> p2d_frame.len >= 12'h009)
    else $error("peer frame too short");
  AST_D_LONG: assert property (d2p_valid && lng(d2p_frame.kind) |-> d2p_frame.len >= 12'h00A)
    else $error("dev I or S frame too short");
  AST_P_LONG: assert property (p2d_valid && lng(p2d_frame.kind) |-> p2d_frame.len >= 12'h00A)
    else $error("peer I or S frame too short");
  AST_D_INFO: assert property (d2p_valid && cry(d2p_frame.kind) |-> d2p_frame.len <= top(d2p_frame.kind))
    else $error("dev info too long");
  AST_P_INFO: assert property (p2d_valid && cry(p2d_frame.kind) |-> p2d_frame.len <= top(p2d_frame.kind))
    else $error("peer info too long");
endmodule // lpt_assertions
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lpt_pkg::*;
  logic clk = 0, rst_n = 0, ld = 0, dtv = 0, ptv = 0, qd = 0, sn = 0;
  logic [15:0] cms = 16'h0000;
  lpt_cfg_t cfg;
  lpt_frame_t dtf, ptf, prf, drf, prf_o, drf_o;
  logic dtr, busy, ok, prv_o, prj_o, drv_o, dsc_o, drp_o, rtx_o, fl_o;
  logic prv, prj, drv, dsc, drp, rtx, fl, rd2;
  logic [3:0] rdst;
  int miscompares = 0, num_checks = 0;
  always #2 clk = ~clk;
  lpt_link_if lk ();
  lpt_link_if lk2 ();
  // Short timers so expiries fit in the run
  lpt_dev_end #(.MS_CYC(4), .BUSY_S(1)) lpt_dev_end_inst (.i_ref_clk(clk), .i_arst_n(rst_n), .link(lk),
    .i_cfg(cfg), .i_cfg_load(ld), .i_tx_valid(dtv), .i_tx_frame(dtf), .o_tx_ready(dtr), .i_concat_ms(cms),
    .o_concat_ok(ok), .i_test_rsp_queued(qd), .i_test_rsp_sent(sn), .o_test_rsp_drop(drp_o),
    .o_rx_valid(drv_o), .o_rx_frame(drf_o), .o_rx_discard(), .o_peer_busy(busy), .o_retx_req(rtx_o),
    .o_link_fail(fl_o), .o_retx_dest(rdst), .o_fail_dest());
  // Second end faces the bench, which breaks length rules on purpose
  lpt_dev_end #(.MS_CYC(4), .BUSY_S(1)) lpt_dev_end_inst2 (.i_ref_clk(clk), .i_arst_n(rst_n), .link(lk2),
    .i_cfg(cfg), .i_cfg_load(ld), .i_tx_valid(1'b0), .i_tx_frame(dtf), .o_tx_ready(), .i_concat_ms(cms),
    .o_concat_ok(), .i_test_rsp_queued(qd), .i_test_rsp_sent(sn), .o_test_rsp_drop(), .o_rx_valid(),
    .o_rx_frame(), .o_rx_discard(dsc_o), .o_peer_busy(), .o_retx_req(), .o_link_fail(), .o_retx_dest(),
    .o_fail_dest());
  lpt_peer_end lpt_peer_end_inst (.i_ref_clk(clk), .i_arst_n(rst_n), .link(lk), .i_cfg(cfg), .i_cfg_load(ld),
    .i_tx_valid(ptv), .i_tx_frame(ptf), .o_tx_reject(prj_o), .o_rx_valid(prv_o), .o_rx_frame(prf_o),
    .o_rx_discard());
  lpt_assertions lpt_assertions_inst (.i_ref_clk(clk), .i_arst_n(rst_n), .d2p_valid(lk.d2p_valid),
    .d2p_frame(lk.d2p_frame), .d2p_key(lk.d2p_key), .p2d_valid(lk.p2d_valid), .p2d_frame(lk.p2d_frame),
    .p2d_key(lk.p2d_key));
  // ------------------------------
  // Sticky capture of output pulses
  // ------------------------------
  always @(posedge clk) begin
    if (prv_o) prf <= prf_o;
    if (drv_o) drf <= drf_o;
    {prv, prj, drv, dsc} <= {prv, prj, drv, dsc} | {prv_o, prj_o, drv_o, dsc_o};
    {drp, rtx, fl, rd2} <= {drp, rtx, fl, rd2} | {drp_o, rtx_o, fl_o, rdst[2]};
  end
  task clr;
    {prv, prj, drv, dsc, drp, rtx, fl, rd2} = '0;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task stop_test;
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wf(ref logic f, input logic v, input int n);
    int c;
    for (c = 0; c < n && f !== v; c++) cyc(1);
    chk(f, v);
    if (f !== v) stop_test;
  endtask
  task dtx(input lpt_kind_t k, input logic [11:0] l, input logic [1:0] d);
    dtf = '{k, l, 1'b0, d, 7'h00};
    dtv = 1;
    wf(dtr, 1, 20);
    cyc(1);
    dtv = 0;
    cyc(1);
  endtask
  task ptx(input lpt_kind_t k, input logic [11:0] l);
    ptf = '{k, l, 1'b0, 2'h0, 7'h00};
    ptv = 1;
    cyc(1);
    ptv = 0;
    cyc(1);
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    cfg = LPT_CFG_DFLT;
    dtf = '0;
    ptf = '0;
    clr;
    lk2.p2d_valid = 0;
    lk2.p2d_key = 0;
    lk2.p2d_frame = '0;
    cyc(6);
    rst_n = 1;
    cfg.max_info_len = 12'h2BC;
    cfg.ttl_ms = 16'h0005;
    cfg.rej_s = 12'h001;
    cfg.conn_retry = 3'h1;
    cfg.tp_ms[2] = 16'h0003;
    cfg.phy_delay_ms = 16'h0002;
    ld = 1;
    cyc(1);
    ld = 0;
    cms = 16'h1388;
    cyc(1);
    chk(ok, 1);
    cms = 16'h1389;
    cyc(1);
    chk(ok, 0);
    clr;
    dtx(LPT_UI, 12'h009, 2'h0);
    wf(prv, 1, 5);
    chk(prf.len, 12'h009);
    clr;
    dtx(LPT_UI, 12'h008, 2'h0);
    dtx(LPT_UI, 12'h2CE, 2'h1);
    cyc(5);
    chk(prv, 0);
    clr;
    ptx(LPT_S_RR, 12'h009);
    cyc(2);
    chk({prj, drv}, 2'h2);
    clr;
    ptx(LPT_S_RR, 12'h00A);
    wf(drv, 1, 5);
    chk(drf.kind, LPT_S_RR);
    clr;
    ptx(LPT_U_RSP, 12'h009);
    wf(drv, 1, 5);
    clr;
    ptx(LPT_UI, 12'h2CD);
    wf(drv, 1, 5);
    chk(drf.len, 12'h2CD);
    clr;
    ptx(LPT_UI, 12'h2CE);
    cyc(2);
    chk({prj, drv}, 2'h2);
    clr;
    lk2.p2d_frame = '{LPT_UI, 12'h008, 1'b0, 2'h0, 7'h00};
    lk2.p2d_valid = 1;
    lk2.p2d_key = 1;
    cyc(1);
    lk2.p2d_valid = 0;
    lk2.p2d_key = 0;
    lk2.p2d_frame = ~lk2.p2d_frame;
    wf(dsc, 1, 5);
    ptx(LPT_BUSY_CMD, 12'h009);
    wf(busy, 1, 5);
    chk(dtr, 0);
    ptx(LPT_READY, 12'h009);
    wf(busy, 0, 5);
    ptx(LPT_BUSY_RSP, 12'h009);
    wf(busy, 1, 5);
    cyc(3900);
    chk(busy, 1);
    wf(busy, 0, 200);
    clr;
    qd = 1;
    cyc(1);
    qd = 0;
    cyc(12);
    chk(drp, 0);
    wf(drp, 1, 20);
    clr;
    qd = 1;
    cyc(1);
    qd = 0;
    sn = 1;
    cyc(1);
    sn = 0;
    cyc(40);
    chk(drp, 0);
    clr;
    dtx(LPT_UI, 12'h009, 2'h2);
    cyc(12);
    chk(rd2, 0);
    wf(rd2, 1, 20);
    repeat (4) dtx(LPT_I_CMD, 12'h00A, 2'h0);
    cyc(4);
    chk(prf.kind, LPT_S_ACKREQ);
    clr;
    dtx(LPT_S_REJ, 12'h00A, 2'h0);
    cyc(3900);
    chk(rtx, 0);
    wf(rtx, 1, 200);
    chk(fl, 0);
    clr;
    dtx(LPT_S_REJ, 12'h00A, 2'h0);
    wf(fl, 1, 4200);
    chk(rtx, 0);
    cfg.quiet = 1'b1;
    ld = 1;
    cyc(1);
    ld = 0;
    clr;
    dtx(LPT_S_REJ, 12'h00A, 2'h0);
    cyc(4100);
    chk({rtx, fl}, 2'h0);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
